// file: hw/ext_data_pins_pkg.sv
// Package of constants for the shared external data bus / port F pin block.
package ext_data_pins_pkg;
  localparam int unsigned LINE_COUNT = 16;
  localparam int unsigned LOW_GROUP_LINES = 7;
  localparam int unsigned LOW_GROUP_PORT_BIT = 9;
  localparam int unsigned HIGH_GROUP_PORT_BIT = 0;
  localparam logic [15:0] PULLUP_RESET = 16'hffff;
  localparam logic [15:0] PERIPH_EN_RESET = 16'hffff;
  localparam logic [15:0] DIR_RESET = 16'h0000;
  localparam logic [15:0] PORT_OUT_RESET = 16'h0000;
  localparam logic BUS_DRIVE_HOLD_RESET = 1'b0;
  localparam logic [15:0] READ_LATCH_RESET = 16'h0000;
endpackage

// file: hw/ext_data_bus_port_f_pins.sv
// Pin control for the sixteen external data lines shared with port F.
`timescale 1ns/1ps
`default_nettype none
// Every pad control is registered, so a configuration change reaches the pads
// one cycle after it is presented.
// Pad inputs are filtered before use, which keeps a ringing line from being
// taken as data but adds latency to both the port input and the read latch.
// The output enable of a bus line follows the raw read strobe, so a read turns
// the bus around without waiting for the filter.
module ext_data_bus_port_f_pins
  import ext_data_pins_pkg::*;
#(
  parameter int unsigned WIDTH = LINE_COUNT
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Control and configuration bits, indexed by port F bit number.
  input wire logic bus_drive_hold,
  input wire logic [15:0] port_f_pullup_reg,
  input wire logic [15:0] periph_enable,
  input wire logic [15:0] port_dir_out,
  input wire logic [15:0] port_out_data,
  // External memory interface side, indexed by data bit number.
  input wire logic bus_cycle_active,
  input wire logic bus_write,
  input wire logic [15:0] bus_write_data,
  input wire logic read_strobe_n,
  output logic [15:0] bus_read_data,
  // Port F input values, indexed by port F bit number.
  output logic [15:0] port_in_data,
  // Pads, indexed by data bit number.
  input wire logic [15:0] pad_in,
  output logic [15:0] pad_out,
  output logic [15:0] pad_oe,
  output logic [15:0] pad_pullup_en
);

  // The pin mapping is fixed in hardware, so other widths cannot be served.
  if (WIDTH != LINE_COUNT) begin : g_bad_width
    $error("ext_data_bus_port_f_pins: WIDTH must be 16.");
  end

  // The two groups must cover the port exactly, or a port bit would be lost.
  if (LOW_GROUP_LINES + LOW_GROUP_PORT_BIT != LINE_COUNT) begin : g_bad_map
    $error("ext_data_bus_port_f_pins: line groups do not cover the port.");
  end

  // Data bit to port F bit number.
  function automatic logic [3:0] port_bit_of(input int unsigned d);
    if (d < LOW_GROUP_LINES) begin
      port_bit_of = 4'(d + LOW_GROUP_PORT_BIT);
    end else begin
      port_bit_of = 4'(d - LOW_GROUP_LINES + HIGH_GROUP_PORT_BIT);
    end
  endfunction

  // Reorder a port-F-indexed vector into data bit order.
  function automatic logic [15:0] to_data_order(input logic [15:0] p);
    logic [15:0] r;
    r = 16'h0000;
    for (int unsigned d = 0; d < LINE_COUNT; d++) begin
      r[d] = p[port_bit_of(d)];
    end
    to_data_order = r;
  endfunction

  logic [15:0] sync1;
  logic [15:0] sync2;
  logic [15:0] sync3;
  logic [15:0] pad_stable;
  logic [2:0] strobe_sync;
  logic strobe_stable;
  logic strobe_prev;
  logic read_rise;
  logic [15:0] next_pad_oe;
  logic [15:0] en_d;
  logic [15:0] dir_d;
  logic [15:0] out_d;
  logic [15:0] pu_d;

  assign en_d = to_data_order(periph_enable);
  assign dir_d = to_data_order(port_dir_out);
  assign out_d = to_data_order(port_out_data);
  assign pu_d = to_data_order(port_f_pullup_reg);

  // Pads come from outside the clock domain and pass three stages first.
  // Only the second stage reads the first, so a metastable first stage
  // never reaches the filter directly.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sync1 <= 16'h0000;
      sync2 <= 16'h0000;
      sync3 <= 16'h0000;
    end else begin
      sync1 <= pad_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // A line changes only when stages two and three agree, which filters one-cycle glitches.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pad_stable <= 16'h0000;
    end else begin
      for (int unsigned d = 0; d < LINE_COUNT; d++) begin
        if (sync2[d] == sync3[d]) begin
          pad_stable[d] <= sync3[d];
        end
      end
    end
  end

  // The read strobe is filtered the same way for latching; it resets to its
  // idle high level so that leaving reset does not look like a rising edge.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      strobe_sync <= 3'h7;
      strobe_stable <= 1'b1;
    end else begin
      strobe_sync <= {strobe_sync[1:0], read_strobe_n};
      if (strobe_sync[1] == strobe_sync[2]) begin
        strobe_stable <= strobe_sync[2];
      end
    end
  end

  // Last filtered strobe level, kept to find the rising edge.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      strobe_prev <= 1'b1;
    end else begin
      strobe_prev <= strobe_stable;
    end
  end

  // The edge is seen only after filtering, so the memory must hold its data
  // a few cycles past the strobe edge.
  assign read_rise = strobe_stable && !strobe_prev;

  // Read data is captured on the rising strobe from the filtered pads.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bus_read_data <= READ_LATCH_RESET;
    end else if (read_rise) begin
      bus_read_data <= pad_stable;
    end
  end

  // Port F input register, presented in port F bit order.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      port_in_data <= 16'h0000;
    end else begin
      for (int unsigned d = 0; d < LINE_COUNT; d++) begin
        port_in_data[port_bit_of(d)] <= pad_stable[d];
      end
    end
  end

  // Pull-up enables follow the pull-up register bit for bit; one bit never
  // touches another line, and reset turns every pull-up on.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pad_pullup_en <= PULLUP_RESET;
    end else begin
      pad_pullup_en <= pu_d;
    end
  end

  // Output level: bus lines carry write data, port lines their port bit.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pad_out <= 16'h0000;
    end else begin
      for (int unsigned d = 0; d < LINE_COUNT; d++) begin
        if (en_d[d]) begin
          pad_out[d] <= bus_write_data[d];
        end else begin
          pad_out[d] <= out_d[d];
        end
      end
    end
  end

  // Drive decision per line, from the line's role and the bus state.
  always_comb begin
    next_pad_oe = 16'h0000;
    for (int unsigned d = 0; d < LINE_COUNT; d++) begin
      if (!en_d[d]) begin
        next_pad_oe[d] = dir_d[d];
      end else if (bus_cycle_active) begin
        next_pad_oe[d] = bus_write && read_strobe_n;
      end else begin
        next_pad_oe[d] = bus_drive_hold;
      end
    end
  end

  // Output enable. Enable bits reset to the bus role at the config source;
  // here the pads stay undriven through reset whatever the inputs say.
  // The raw strobe turns a bus line around on the next edge, so pad and memory do not
  // fight; the cost is that a strobe glitch briefly floats the bus.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pad_oe <= 16'h0000;
    end else begin
      pad_oe <= next_pad_oe;
    end
  end

endmodule
`default_nettype wire

// file: testbench/ext_pins_asserts.sv
// Assertions for the shared data line pin block.
`timescale 1ns/1ps
`default_nettype none
module ext_pins_asserts (
  input wire logic ref_clk, sys_rst, bus_drive_hold, bus_cycle_active, read_strobe_n,
  input wire logic [15:0] port_f_pullup_reg, periph_enable, port_dir_out, port_out_data,
  input wire logic [15:0] bus_read_data, pad_in, pad_out, pad_oe, pad_pullup_en
);
  logic rs = 1'b1;
  logic [15:0] pe;
  // Port bits 9..15 are lines 0..6, port bits 0..8 are lines 7..15.
  function automatic logic [15:0] m(input logic [15:0] x);
    return {x[8:0], x[15:9]};
  endfunction
  // Copies from the previous edge, since pad controls answer one edge late.
  always_ff @(posedge ref_clk) begin
    rs <= sys_rst;
    pe <= m(periph_enable);
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  property p_rst; rs |-> pad_oe == 16'h0000 && pad_pullup_en == 16'hffff; endproperty
  a_rst: assert property (p_rst) else $error("reset pads");
  property p_pu; !rs |-> pad_pullup_en == m($past(port_f_pullup_reg)); endproperty
  a_pu: assert property (p_pu) else $error("pull-up");
  property p_poe; !rs |-> (pad_oe & ~pe) == (m($past(port_dir_out)) & ~pe); endproperty
  a_poe: assert property (p_poe) else $error("port dir");
  property p_out; !rs |-> (pad_out & ~pe & pad_oe) == (m($past(port_out_data)) & ~pe & pad_oe); endproperty
  a_out: assert property (p_out) else $error("port out");
  property p_idle; !rs && !$past(bus_cycle_active) |-> (pad_oe & pe) == (pe & {16{$past(bus_drive_hold)}}); endproperty
  a_idle: assert property (p_idle) else $error("idle drive");
  property p_rd; !rs && $past(bus_cycle_active && !read_strobe_n) |-> (pad_oe & pe) == 16'h0000; endproperty
  a_rd: assert property (p_rd) else $error("read drive");
  property p_lat; !read_strobe_n [*4] ##1 (read_strobe_n && $stable(pad_in)) [*6] |-> bus_read_data == pad_in; endproperty
  a_lat: assert property (p_lat) else $error("read latch");
  property p_keep; read_strobe_n [*8] |-> $stable(bus_read_data); endproperty
  a_keep: assert property (p_keep) else $error("read hold");
  // Main scenarios: a read, a port line, an idle held bus.
  cover property (!read_strobe_n ##1 read_strobe_n);
  cover property (pe != 16'hffff);
  cover property (bus_drive_hold && !bus_cycle_active);
endmodule
bind ext_data_bus_port_f_pins ext_pins_asserts chk (.*);
`default_nettype wire

// file: testbench/ext_mem_model.sv
// External memory model on the shared data lines.
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
  input wire logic mem_oe_n,
  input wire logic [15:0] mem_word, pad_out, pad_oe, pad_pullup_en,
  output logic [15:0] pad_in
);
  // A floating line without pull-up shows the inverse, so a stale value cannot pass.
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & (mem_oe_n ? (pad_pullup_en | ~pad_out) : mem_word));
endmodule
`default_nettype wire

// file: testbench/ext_data_bus_port_f_pins_bench.sv
// Self-checking bench for the shared data line pin block.
`timescale 1ns/1ps
`default_nettype none
module ext_data_bus_port_f_pins_bench;
  logic ref_clk = 1'b0, sys_rst = 1'b1, bus_drive_hold = 1'b0, bus_cycle_active = 1'b0, bus_write = 1'b0;
  logic read_strobe_n = 1'b1, mem_oe_n = 1'b1;
  logic [15:0] port_f_pullup_reg = 16'hffff, periph_enable = 16'hffff, port_dir_out = 16'h0000;
  logic [15:0] port_out_data = 16'h0200, bus_write_data = 16'h3c5a, mem_word = 16'ha5c3;
  logic [15:0] bus_read_data, port_in_data, pad_in, pad_out, pad_oe, pad_pullup_en;
  int error_cnt = 0, checks_done = 0;
  ext_data_bus_port_f_pins DUT (.*);
  ext_mem_model mem (.*);
  always #12.5 ref_clk = ~ref_clk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t %h %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic t_port;
    periph_enable = 16'hfdfe;
    port_dir_out = 16'h0200;
    port_f_pullup_reg = 16'hfdff;
    tick(1);
    chk(pad_oe, 16'h0001);
    chk(pad_pullup_en, 16'hfffe);
    chk(pad_out & pad_oe, 16'h0001);
    port_dir_out = 16'h0001;
    tick(1);
    chk(pad_oe, 16'h0080);
    tick(6);
    chk(port_in_data, 16'hfdfe);
    $display("port test done");
  endtask
  task automatic t_bus;
    periph_enable = 16'hffff;
    bus_drive_hold = 1'b1;
    tick(1);
    chk(pad_out, 16'h3c5a);
    chk(pad_oe, 16'hffff);
    bus_cycle_active = 1'b1;
    read_strobe_n = 1'b0;
    mem_oe_n = 1'b0;
    tick(4);
    chk(pad_oe, 16'h0000);
    read_strobe_n = 1'b1;
    tick(6);
    chk(bus_read_data, 16'ha5c3);
    mem_oe_n = 1'b1;
    $display("bus test done");
  endtask
  task automatic t_write;
    bus_write = 1'b1;
    bus_write_data = 16'h1234;
    tick(1);
    chk(pad_oe, 16'hffff);
    chk(pad_out, 16'h1234);
    bus_cycle_active = 1'b0;
    bus_write = 1'b0;
    bus_drive_hold = 1'b0;
    tick(1);
    chk(pad_oe, 16'h0000);
    $display("write test done");
  endtask
  // Reset for five edges, checking the pads while it is held.
  initial begin
    tick(4);
    chk(pad_oe | ~pad_pullup_en, 16'h0000);
    tick(1);
    sys_rst = 1'b0;
    t_port;
    t_bus;
    t_write;
    end_of_test;
  end
  // The tests take well under a microsecond, so this only fires on a hang.
  initial begin
    #20000;
    error_cnt++;
    end_of_test;
  end
endmodule
`default_nettype wire
